//--- verilog/fmsp_serial_port.sv
// Purpose: Four-mode serial port with AXI4-Lite register access.
// Assumes: Timer overflow pulses arrive on the same clock; serial pins are asynchronous.
// Notes:   Mode 0 shift clock and data outputs lag their divider state by one cycle.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module fmsp_serial_port (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic [fmsp_pkg::ADDR_W-1:0] i_axi_awaddr,
  input  wire logic                        i_axi_awvalid,
  output logic                             o_axi_awready,
  input  wire logic [31:0]                 i_axi_wdata,
  input  wire logic [3:0]                  i_axi_wstrb,
  input  wire logic                        i_axi_wvalid,
  output logic                             o_axi_wready,
  output logic [1:0]                       o_axi_bresp,
  output logic                             o_axi_bvalid,
  input  wire logic                        i_axi_bready,
  input  wire logic [fmsp_pkg::ADDR_W-1:0] i_axi_araddr,
  input  wire logic                        i_axi_arvalid,
  output logic                             o_axi_arready,
  output logic [31:0]                      o_axi_rdata,
  output logic [1:0]                       o_axi_rresp,
  output logic                             o_axi_rvalid,
  input  wire logic                        i_axi_rready,
  input  wire logic                        i_timer1_ovf,
  input  wire logic                        i_timer2_ovf,
  input  wire logic                        i_rxd,
  output logic                             o_rxd,
  output logic                             o_rxd_oe,
  output logic                             o_txd
);
  import fmsp_pkg::*;

  // ---------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------
  logic           mode_hi_q, mode_lo_q, mpf_q, ren_q, tx9_q, rx9_q, txf_q, rxf_q, ferr_q;
  logic           efs_q, bds_q, ttsel_q, rtsel_q;
  logic [7:0]     rx_buf_q;
  logic [1:0]     mode;
  logic           nine;
  logic           bvalid_q, rvalid_q;
  logic [1:0]     bresp_q, rresp_q;
  logic [31:0]    rdata_q;
  logic           wr_go, rd_go, wr_lane0, wr_ctrl, wr_data, wr_pwr, wr_tsel;
  logic           wr_mapped, rd_mapped;
  logic [7:0]     wd, rd_byte;
  logic           rx_s1_q, rx_s2_q, rx_prev_q;
  logic           m2_half_q, m2_tick, tx_tick, rx_tick;
  logic [2:0]     m0_div_q;
  fmsp_tx_state_e tx_state_q;
  logic [10:0]    tx_sh_q;
  logic [3:0]     tx_cnt_q, tx_idx_q, tx_last;
  fmsp_rx_state_e rx_state_q;
  logic [7:0]     rx_sh_q;
  logic [3:0]     rx_cnt_q, rx_idx_q, rx_last;
  logic           rx_s7_q, rx_s8_q, rx_ninth_q, rx_bit;
  logic           txf_set, rx_final, rx_fbit, rx_accept, sync_done, ferr_set, sync_rx_start;
  logic           txd_q, rxd_q, rxd_oe_q;

  // Mode decode and frame length.
  assign mode    = {mode_hi_q, mode_lo_q};
  assign nine    = mode[1];
  assign tx_last = nine ? LAST_9BIT : LAST_8BIT;
  assign rx_last = nine ? LAST_9BIT : LAST_8BIT;

  // ---------------------------------------------------------------
  // AXI4-Lite slave.
  // ---------------------------------------------------------------
  // Address and data are taken together, in one cycle, whichever arrived first.
  assign wr_go         = i_axi_awvalid & i_axi_wvalid & ~bvalid_q;
  assign o_axi_awready = wr_go;
  assign o_axi_wready  = wr_go;
  assign wr_lane0      = wr_go & i_axi_wstrb[0];
  assign wd            = i_axi_wdata[7:0];
  assign wr_ctrl       = wr_lane0 && (i_axi_awaddr == OFF_CTRL);
  assign wr_data       = wr_lane0 && (i_axi_awaddr == OFF_DATA);
  assign wr_pwr        = wr_lane0 && (i_axi_awaddr == OFF_PWR);
  assign wr_tsel       = wr_lane0 && (i_axi_awaddr == OFF_TSEL);
  assign wr_mapped     = (i_axi_awaddr == OFF_CTRL) || (i_axi_awaddr == OFF_DATA) ||
                         (i_axi_awaddr == OFF_PWR) || (i_axi_awaddr == OFF_TSEL);
  assign rd_go         = i_axi_arvalid & ~rvalid_q;
  assign o_axi_arready = rd_go;
  assign rd_mapped     = (i_axi_araddr == OFF_CTRL) || (i_axi_araddr == OFF_DATA) ||
                         (i_axi_araddr == OFF_PWR) || (i_axi_araddr == OFF_TSEL);

  // Write response: one cycle after acceptance, held until bready.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data mux; bit 7 of the control register depends on error_flag_select.
  always_comb begin
    rd_byte = 8'h00;
    case (i_axi_araddr)
      OFF_CTRL: rd_byte = {efs_q ? ferr_q : mode_hi_q, mode_lo_q, mpf_q, ren_q,
                           tx9_q, rx9_q, txf_q, rxf_q};
      OFF_DATA: rd_byte = rx_buf_q;
      OFF_PWR:  rd_byte = {bds_q, efs_q, 6'h00};
      OFF_TSEL: rd_byte = {6'h00, rtsel_q, ttsel_q};
      default:  rd_byte = 8'h00;
    endcase
  end

  // Read response: one cycle after acceptance, held until rready.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= {24'h00_0000, rd_byte};
    end else if (i_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_axi_bvalid = bvalid_q;
  assign o_axi_bresp  = bresp_q;
  assign o_axi_rvalid = rvalid_q;
  assign o_axi_rresp  = rresp_q;
  assign o_axi_rdata  = rdata_q;

  // ---------------------------------------------------------------
  // Control, power and timer-select registers.
  // ---------------------------------------------------------------
  // Hardware sets are applied after the software write, so a set wins a clash.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {mode_hi_q, mode_lo_q, mpf_q, ren_q, tx9_q, rx9_q, txf_q, rxf_q} <= CTRL_RESET;
      ferr_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        if (efs_q) begin
          ferr_q <= wd[CTRL_MODE_HI];
        end else begin
          mode_hi_q <= wd[CTRL_MODE_HI];
        end
        mode_lo_q <= wd[CTRL_MODE_LO];
        mpf_q     <= wd[CTRL_MPF];
        ren_q     <= wd[CTRL_REN];
        tx9_q     <= wd[CTRL_TX9];
        rx9_q     <= wd[CTRL_RX9];
        txf_q     <= wd[CTRL_TXF];
        rxf_q     <= wd[CTRL_RXF];
      end
      if (txf_set) begin
        txf_q <= 1'b1;
      end
      if (rx_accept || sync_done) begin
        rxf_q <= 1'b1;
      end
      if (rx_accept) begin
        rx9_q <= rx_fbit;
      end
      if (ferr_set) begin
        ferr_q <= 1'b1;
      end
    end
  end

  // Power control and per-direction timer selection.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      efs_q   <= 1'b0;
      bds_q   <= 1'b0;
      ttsel_q <= 1'b0;
      rtsel_q <= 1'b0;
    end else begin
      if (wr_pwr) begin
        efs_q <= wd[PWR_EFS];
        bds_q <= wd[PWR_BDS];
      end
      if (wr_tsel) begin
        ttsel_q <= wd[TSEL_TX];
        rtsel_q <= wd[TSEL_RX];
      end
    end
  end

  // Receive buffer loads only on an accepted frame or a completed mode 0 shift receive.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_buf_q <= 8'h00;
    end else if (rx_accept || sync_done) begin
      rx_buf_q <= rx_sh_q;
    end
  end

  // ---------------------------------------------------------------
  // Rate generation.
  // ---------------------------------------------------------------
  // Mode 2 oversample tick: every cycle (/16 bit) or every other cycle (/32 bit).
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      m2_half_q <= 1'b0;
    end else begin
      m2_half_q <= ~m2_half_q;
    end
  end

  assign m2_tick = bds_q | m2_half_q;
  // Variable modes take one oversample tick per timer overflow, so bit = overflow/16.
  assign tx_tick = (mode == MODE_9FIX) ? m2_tick : (ttsel_q ? i_timer2_ovf : i_timer1_ovf);
  assign rx_tick = (mode == MODE_9FIX) ? m2_tick : (rtsel_q ? i_timer2_ovf : i_timer1_ovf);

  // Mode 0 divide-by-six bit timer, held at zero when no shift transfer runs.
  always_ff @(posedge i_clk) begin
    if (i_rst || (tx_state_q != TX_SYNC && rx_state_q != RX_SYNC)) begin
      m0_div_q <= 3'd0;
    end else if (m0_div_q == M0_DIV_LAST) begin
      m0_div_q <= 3'd0;
    end else begin
      m0_div_q <= m0_div_q + 3'd1;
    end
  end

  // Two-flop synchroniser on the serial input, plus a delayed copy for edges.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= i_rxd;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter.
  // ---------------------------------------------------------------
  // A data write while the transmitter is busy is dropped.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= 11'h7ff;
      tx_cnt_q   <= 4'd0;
      tx_idx_q   <= 4'd0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_cnt_q <= 4'd0;
          tx_idx_q <= 4'd0;
          if (wr_data && mode == MODE_SHIFT && rx_state_q == RX_IDLE) begin
            tx_state_q <= TX_SYNC;
            tx_sh_q    <= {3'b111, wd};
          end else if (wr_data && mode != MODE_SHIFT) begin
            tx_state_q <= TX_ASYNC;
            tx_sh_q    <= nine ? {1'b1, tx9_q, wd, 1'b0}
                               : {2'b11, wd, 1'b0};
          end
        end
        TX_ASYNC: begin
          if (tx_tick) begin
            tx_cnt_q <= tx_cnt_q + 4'd1;
            if (tx_cnt_q == OS_LAST) begin
              tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
              tx_idx_q <= tx_idx_q + 4'd1;
              if (tx_idx_q == tx_last) begin
                tx_state_q <= TX_IDLE;
              end
            end
          end
        end
        TX_SYNC: begin
          if (m0_div_q == M0_DIV_LAST) begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_idx_q <= tx_idx_q + 4'd1;
            if (tx_idx_q == M0_LAST_BIT) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Transmit flag: start of stop bit when async, end of eighth bit in mode 0.
  assign txf_set = (tx_state_q == TX_ASYNC && tx_tick && tx_cnt_q == OS_LAST &&
                    (tx_idx_q + 4'd1) == tx_last) ||
                   (tx_state_q == TX_SYNC && m0_div_q == M0_DIV_LAST &&
                    tx_idx_q == M0_LAST_BIT);

  // ---------------------------------------------------------------
  // Receiver.
  // ---------------------------------------------------------------
  assign rx_bit        = fmsp_maj3(rx_s7_q, rx_s8_q, rx_s2_q);
  assign sync_rx_start = (mode == MODE_SHIFT) && ren_q && !rxf_q && !wr_data &&
                         (tx_state_q == TX_IDLE);

  // Oversampling receiver for modes 1-3 and shift receiver for mode 0.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q    <= 8'h00;
      rx_cnt_q   <= 4'd0;
      rx_idx_q   <= 4'd0;
      rx_s7_q    <= 1'b1;
      rx_s8_q    <= 1'b1;
      rx_ninth_q <= 1'b0;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= 4'd0;
          rx_idx_q <= 4'd0;
          if (mode != MODE_SHIFT && ren_q && rx_prev_q && !rx_s2_q) begin
            rx_state_q <= RX_ASYNC;
          end else if (sync_rx_start) begin
            rx_state_q <= RX_SYNC;
          end
        end
        RX_ASYNC: begin
          if (!ren_q) begin
            rx_state_q <= RX_IDLE;
          end else if (rx_tick) begin
            rx_cnt_q <= rx_cnt_q + 4'd1;
            if (rx_cnt_q == OS_S7) begin
              rx_s7_q <= rx_s2_q;
            end
            if (rx_cnt_q == OS_S8) begin
              rx_s8_q <= rx_s2_q;
            end
            if (rx_cnt_q == OS_S9) begin
              if (rx_idx_q == 4'd0 && rx_bit) begin
                rx_state_q <= RX_IDLE;
              end else if (rx_idx_q == rx_last) begin
                rx_state_q <= RX_IDLE;
              end
              if (rx_idx_q >= DATA_FIRST && rx_idx_q <= DATA_LAST) begin
                rx_sh_q <= {rx_bit, rx_sh_q[7:1]};
              end
              if (nine && rx_idx_q == NINTH_IDX) begin
                rx_ninth_q <= rx_bit;
              end
            end
            if (rx_cnt_q == OS_LAST) begin
              rx_idx_q <= rx_idx_q + 4'd1;
            end
          end
        end
        RX_SYNC: begin
          if (!ren_q) begin
            rx_state_q <= RX_IDLE;
          end else begin
            if (m0_div_q == M0_RISE) begin
              rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
            end
            if (m0_div_q == M0_DIV_LAST) begin
              rx_idx_q <= rx_idx_q + 4'd1;
              if (rx_idx_q == M0_LAST_BIT) begin
                rx_state_q <= RX_IDLE;
              end
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Final decision at the middle of the stop bit.
  assign rx_final  = (rx_state_q == RX_ASYNC) && ren_q && rx_tick &&
                     (rx_cnt_q == OS_S9) && (rx_idx_q == rx_last);
  assign rx_fbit   = nine ? rx_ninth_q : rx_bit;
  assign rx_accept = rx_final && !rxf_q && (!mpf_q || rx_fbit);
  assign ferr_set  = rx_final && !rx_bit;
  assign sync_done = (rx_state_q == RX_SYNC) && ren_q && (m0_div_q == M0_DIV_LAST) &&
                     (rx_idx_q == M0_LAST_BIT);

  // ---------------------------------------------------------------
  // Pin drivers.
  // ---------------------------------------------------------------
  // TXD carries the shift clock in mode 0 for either direction, else the frame.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      txd_q    <= 1'b1;
      rxd_q    <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else begin
      if (tx_state_q == TX_SYNC || rx_state_q == RX_SYNC) begin
        txd_q <= (m0_div_q >= M0_RISE);
      end else if (tx_state_q == TX_ASYNC) begin
        txd_q <= tx_sh_q[0];
      end else begin
        txd_q <= 1'b1;
      end
      rxd_q    <= (tx_state_q == TX_SYNC) ? tx_sh_q[0] : 1'b1;
      rxd_oe_q <= (tx_state_q == TX_SYNC);
    end
  end

  assign o_txd    = txd_q;
  assign o_rxd    = rxd_q;
  assign o_rxd_oe = rxd_oe_q;

endmodule

`default_nettype wire

//--- verilog/fmsp_pkg.sv
// Purpose: Shared constants and types for the four-mode serial port.
// Assumes: 32-bit AXI4-Lite register access, one clock at 125 MHz.
// Notes:   Every offset, bit position and timing count lives here, with the control register reset value.
`default_nettype none

package fmsp_pkg;

  // ---------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h98;
  localparam logic [7:0]  OFF_DATA    = 8'h9c;
  localparam logic [7:0]  OFF_PWR     = 8'ha0;
  localparam logic [7:0]  OFF_TSEL    = 8'ha4;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_MPF     = 5;
  localparam int CTRL_REN     = 4;
  localparam int CTRL_TX9     = 3;
  localparam int CTRL_RX9     = 2;
  localparam int CTRL_TXF     = 1;
  localparam int CTRL_RXF     = 0;
  localparam int PWR_EFS      = 6;
  localparam int PWR_BDS      = 7;
  localparam int TSEL_TX      = 0;
  localparam int TSEL_RX      = 1;

  // ---------------------------------------------------------------
  // Modes and timing counts.
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'b00;
  localparam logic [1:0] MODE_8BIT  = 2'b01;
  localparam logic [1:0] MODE_9FIX  = 2'b10;
  localparam logic [1:0] MODE_9VAR  = 2'b11;
  localparam logic [2:0] M0_DIV_LAST = 3'd5;
  localparam logic [2:0] M0_RISE     = 3'd3;
  localparam logic [3:0] M0_LAST_BIT = 4'd7;
  localparam logic [3:0] OS_LAST     = 4'd15;
  localparam logic [3:0] OS_S7       = 4'd7;
  localparam logic [3:0] OS_S8       = 4'd8;
  localparam logic [3:0] OS_S9       = 4'd9;
  localparam logic [3:0] LAST_8BIT   = 4'd9;
  localparam logic [3:0] LAST_9BIT   = 4'd10;
  localparam logic [3:0] NINTH_IDX   = 4'd9;
  localparam logic [3:0] DATA_FIRST  = 4'd1;
  localparam logic [3:0] DATA_LAST   = 4'd8;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC  = 3'b100
  } fmsp_tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_ASYNC = 3'b010,
    RX_SYNC  = 3'b100
  } fmsp_rx_state_e;

  // Two-of-three vote used for every bit received in modes 1-3; mode 0 takes the synchronised pin directly.
  function automatic logic fmsp_maj3(input logic a, input logic b, input logic c);
    fmsp_maj3 = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

`default_nettype wire

//--- test/fmsp_peer.sv
// Purpose: Remote serial peer that sends one asynchronous frame on request.
// Assumes: Sixteen clocks per bit, as in mode 2 with doubling set.
// Notes:   The line idles high between frames, as a pulled-up line does.
`timescale 1ns/1ps
`default_nettype none
module fmsp_peer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire logic [10:0] i_frame,
  output logic             o_line
);
  logic [10:0] sh_q;
  logic [3:0]  div_q;
  // Shifts the frame out LSB first, refilling with idle ones.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sh_q  <= 11'h7ff;
      div_q <= 4'h0;
    end else if (i_go) begin
      sh_q  <= i_frame;
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'hf) begin
        sh_q <= {1'b1, sh_q[10:1]};
      end
    end
  end
  assign o_line = sh_q[0];
endmodule
`default_nettype wire

//--- test/fmsp_serial_port_props.sv
// Purpose: Port-level checks of the serial port.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every instance of the port.
`timescale 1ns/1ps
`default_nettype none
module fmsp_serial_port_props
  import fmsp_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_axi_awvalid,
  input wire logic        i_axi_wvalid,
  input wire logic        o_axi_awready,
  input wire logic        o_axi_bvalid,
  input wire logic [1:0]  o_axi_bresp,
  input wire logic        i_axi_bready,
  input wire logic        i_axi_arvalid,
  input wire logic [7:0]  i_axi_araddr,
  input wire logic        o_axi_rvalid,
  input wire logic [31:0] o_axi_rdata,
  input wire logic [1:0]  o_axi_rresp,
  input wire logic        i_axi_rready,
  input wire logic        o_txd,
  input wire logic        o_rxd_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic wr_go;
  assign wr_go = i_axi_awvalid && i_axi_wvalid && !o_axi_bvalid;
  property p_wr_ans; wr_go |=> o_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_rdy; o_axi_awready == wr_go; endproperty
  a_wr_rdy: assert property (p_wr_rdy) else $error("write ready wrong");
  property p_wr_hold; o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_rd_ans; i_axi_arvalid && !o_axi_rvalid |=> o_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_hold; o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  property p_rd_hi; o_axi_rvalid |-> o_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");
  property p_rd_err;
    i_axi_arvalid && !o_axi_rvalid && i_axi_araddr == 8'hb0 |=> o_axi_rresp == RESP_SLVERR && o_axi_rdata == 0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_m0_clk; $fell(o_txd) && o_rxd_oe |-> !o_txd [*3] ##1 o_txd; endproperty
  a_m0_clk: assert property (p_m0_clk) else $error("shift clock shape wrong");
  c_wr: cover property (wr_go);
  c_err: cover property (i_axi_arvalid && i_axi_araddr == 8'hb0);
  c_m0: cover property ($fell(o_txd) && o_rxd_oe);
endmodule
bind fmsp_serial_port fmsp_serial_port_props i_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_axi_awvalid(i_axi_awvalid), .i_axi_wvalid(i_axi_wvalid), .o_axi_awready(o_axi_awready),
  .o_axi_bvalid(o_axi_bvalid), .o_axi_bresp(o_axi_bresp), .i_axi_bready(i_axi_bready),
  .i_axi_arvalid(i_axi_arvalid), .i_axi_araddr(i_axi_araddr), .o_axi_rvalid(o_axi_rvalid),
  .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp), .i_axi_rready(i_axi_rready),
  .o_txd(o_txd), .o_rxd_oe(o_rxd_oe));
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench of the serial port.
// Assumes: AXI4-Lite master tasks, peer drives the receive pin.
// Notes:   Mode 2 with doubling gives sixteen clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fmsp_pkg::*;
  logic        clk = 0, rst = 1, go = 0, t1ovf = 0, t2ovf = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, rxd_o, rxd_oe, txd, line;
  logic [10:0] frame = 11'h7ff;
  wire logic   rxd_pin = rxd_oe ? rxd_o : line;
  int          n_mismatch = 0, n_compared = 0;
  always #4 clk = ~clk;
  fmsp_serial_port i_dut (.i_clk(clk), .i_rst(rst), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .i_axi_wvalid(wvalid),
    .o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
    .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready), .i_timer1_ovf(t1ovf),
    .i_timer2_ovf(t2ovf), .i_rxd(rxd_pin), .o_rxd(rxd_o), .o_rxd_oe(rxd_oe), .o_txd(txd));
  fmsp_peer i_peer (.i_clk(clk), .i_rst(rst), .i_go(go), .i_frame(frame), .o_line(line));
  // Verdict and counts.
  task automatic results;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    n_mismatch++;
    $display("CHECK FAILED %s exp done got timeout", nm);
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
    for (k = 0; k < 50 && awready !== 1'b1; k++) @(posedge clk);
    awvalid <= 0; wvalid <= 0; bready <= 1;
    for (k = 0; k < 50 && bvalid !== 1'b1; k++) @(posedge clk);
    bready <= 0;
    if (k == 50) tmo("write");
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    araddr <= a; arvalid <= 1;
    for (k = 0; k < 50 && arready !== 1'b1; k++) @(posedge clk);
    arvalid <= 0; rready <= 1;
    for (k = 0; k < 50 && rvalid !== 1'b1; k++) @(posedge clk);
    d = rdata; r = rresp; rready <= 0;
    if (k == 50) tmo("read");
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask
  task automatic send(input logic [10:0] f);
    frame <= f; go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (192) @(posedge clk);
  endtask
  // Reset value and an unmapped place.
  task automatic t_regs;
    rdchk(OFF_CTRL, 32'h0, "ctrl reset");
    rd(8'hb0);
    chk("bad resp", RESP_SLVERR, r);
    chk("bad data", 32'h0, d);
    $display("t_regs done");
  endtask
  // Mode 2 frame with ninth bit set, sampled mid bit.
  task automatic t_tx9;
    int k;
    logic [10:0] b;
    wr(OFF_PWR, 32'h80); wr(OFF_CTRL, 32'h88); wr(OFF_DATA, 32'h5a);
    for (k = 0; k < 100 && txd !== 1'b0; k++) @(posedge clk);
    if (k == 100) tmo("start bit");
    repeat (8) @(posedge clk);
    for (k = 0; k < 11; k++) begin
      b[k] = txd;
      repeat (16) @(posedge clk);
    end
    chk("tx frame", {21'h0, 2'b11, 8'h5a, 1'b0}, b);
    rdchk(OFF_CTRL, 32'h8a, "tx flag");
    $display("t_tx9 done");
  endtask
  // Mode 2 receive, flag and filter discards, receive disabled.
  task automatic t_rx9;
    wr(OFF_CTRL, 32'h90);
    send({2'b10, 8'hc3, 1'b0});
    rdchk(OFF_DATA, 32'hc3, "rx data");
    rdchk(OFF_CTRL, 32'h91, "rx ctrl");
    send({2'b11, 8'h3c, 1'b0});
    rdchk(OFF_DATA, 32'hc3, "flag set keep");
    rdchk(OFF_CTRL, 32'h91, "flag set ctrl");
    wr(OFF_CTRL, 32'hb0);
    send({2'b10, 8'h11, 1'b0});
    rdchk(OFF_CTRL, 32'hb0, "filtered");
    send({2'b11, 8'h77, 1'b0});
    rdchk(OFF_DATA, 32'h77, "address data");
    rdchk(OFF_CTRL, 32'hb5, "address ctrl");
    wr(OFF_CTRL, 32'h80);
    send({2'b11, 8'h55, 1'b0});
    rdchk(OFF_DATA, 32'h77, "rx off data");
    rdchk(OFF_CTRL, 32'h80, "rx off ctrl");
    $display("t_rx9 done");
  endtask
  // Mode 0 transmit, bits taken at shift clock rises, then a receive of the idle line.
  task automatic t_m0;
    int k, n;
    logic p;
    logic [7:0] g;
    n = 0; g = 0;
    wr(OFF_PWR, 32'h0); wr(OFF_CTRL, 32'h0); wr(OFF_DATA, 32'h96);
    p = txd;
    for (k = 0; k < 80; k++) begin
      @(posedge clk);
      if (rxd_oe === 1'b1 && txd === 1'b1 && p === 1'b0) begin
        g = {rxd_o, g[7:1]};
        n++;
      end
      p = txd;
    end
    chk("m0 bits", 32'd8, n);
    chk("m0 data", 32'h96, g);
    rdchk(OFF_CTRL, 32'h02, "m0 flag");
    wr(OFF_CTRL, 32'h10);
    repeat (60) @(posedge clk);
    rdchk(OFF_DATA, 32'hff, "m0 rx data");
    rdchk(OFF_CTRL, 32'h11, "m0 rx flag");
    $display("t_m0 done");
  endtask
  // Mode 1 receive on the timer 2 rate: stop bit, framing error and its stickiness.
  task automatic t_m1;
    t2ovf <= 1;
    wr(OFF_TSEL, 32'h2); wr(OFF_CTRL, 32'h50);
    send({2'b11, 8'ha5, 1'b0});
    rdchk(OFF_DATA, 32'ha5, "m1 data");
    rdchk(OFF_CTRL, 32'h55, "m1 ctrl");
    wr(OFF_PWR, 32'h40); wr(OFF_CTRL, 32'h50);
    send({2'b10, 8'h3c, 1'b0});
    rdchk(OFF_CTRL, 32'hd1, "m1 bad stop");
    wr(OFF_CTRL, 32'hd0);
    send({2'b11, 8'h5a, 1'b0});
    rdchk(OFF_CTRL, 32'hd5, "m1 error kept");
    wr(OFF_CTRL, 32'h50);
    rdchk(OFF_CTRL, 32'h50, "m1 error clear");
    $display("t_m1 done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_tx9();
    t_rx9();
    t_m0();
    t_m1();
    results();
  end
endmodule
`default_nettype wire
